// ---- design/mad_pkg.sv ----
// Package for the multi-axis alarm detector: codes, blink counts, timing
package mad_pkg;

  localparam logic [7:0] CODE_NONE       = 8'h00;
  localparam logic [7:0] CODE_OTHER_AXIS = 8'h35;
  localparam logic [7:0] CODE_NVM_CTRL   = 8'h41;
  localparam logic [7:0] CODE_SENS_PWRUP = 8'h42;
  localparam logic [7:0] CODE_ROT_PWRUP  = 8'h43;
  localparam logic [7:0] CODE_NVM_SENS   = 8'h44;
  localparam logic [7:0] CODE_MOTOR_TYPE = 8'h45;
  localparam logic [7:0] CODE_NOT_HOMED  = 8'h4A;
  localparam logic [7:0] CODE_REGEN_HOT  = 8'h51;

  localparam logic [3:0] BLINK_OTHER_AXIS = 4'h2;
  localparam logic [3:0] BLINK_NVM_CTRL   = 4'h9;
  localparam logic [3:0] BLINK_SENSOR     = 4'h8;
  localparam logic [3:0] BLINK_NOT_HOMED  = 4'h7;
  localparam logic [3:0] BLINK_REGEN_HOT  = 4'h2;

  // LED timing, in milliseconds, and cycle counts at 100 MHz
  localparam int CLK_HZ       = 100_000_000;
  localparam int BLINK_ON_MS  = 200;
  localparam int BLINK_OFF_MS = 200;
  localparam int BLINK_GAP_MS = 1000;
  localparam int BLINK_ON_CYC  = CLK_HZ / 1000 * BLINK_ON_MS;
  localparam int BLINK_OFF_CYC = CLK_HZ / 1000 * BLINK_OFF_MS;
  localparam int BLINK_GAP_CYC = CLK_HZ / 1000 * BLINK_GAP_MS;

  // Fault inputs, all active high levels
  typedef struct packed {
    logic otherAxisAlarm;
    logic nvmCtrlCorrupt;
    logic sensorFaultPwrup;
    logic rotatingPwrup;
    logic nvmSensCorrupt;
    logic motorUnsupported;
    logic absMoveStart;
    logic regenThermalBad;
  } mad_fault_t;

  // Parameter bits held by the driver
  typedef struct packed {
    logic otherAxisAlarmEnable;
    logic regen_overheat_alarm_enable;
    logic absMoveWithoutCoordPermit;
  } mad_cfg_t;

  // Alarm state reported to the host
  typedef struct packed {
    logic       active;
    logic       powerCycleOnly;
    logic [7:0] code;
    logic [3:0] blinks;
  } mad_status_t;

endpackage

// ---- design/mad_led_blinker.sv ----
// LED blinker: repeats a burst of N blinks with a gap while enabled
`timescale 1ns/1ns
module mad_led_blinker #(
  parameter int ON_CYC  = mad_pkg::BLINK_ON_CYC,
  parameter int OFF_CYC = mad_pkg::BLINK_OFF_CYC,
  parameter int GAP_CYC = mad_pkg::BLINK_GAP_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic [3:0] blinks,
  output logic            ledOn
);

  typedef enum logic [2:0] {
    MAD_IDLE = 3'b001,
    MAD_ON   = 3'b010,
    MAD_OFF  = 3'b100
  } mad_blink_state_t;

  mad_blink_state_t stateFf, nxtState;
  logic [31:0]      timerFf, nxtTimer;
  logic [3:0]       countFf, nxtCount;
  logic             ledFf,   nxtLed;

  always_comb begin
    nxtState = stateFf;
    nxtTimer = timerFf;
    nxtCount = countFf;
    nxtLed   = 1'b0;
    if (!enable || blinks == 4'h0) begin
      nxtState = MAD_IDLE;
      nxtTimer = 32'h0;
      nxtCount = 4'h0;
    end else begin
      unique case (stateFf)
        MAD_IDLE: begin
          nxtState = MAD_ON;
          nxtTimer = 32'(ON_CYC - 1);
          nxtCount = blinks;
          nxtLed   = 1'b1;
        end
        MAD_ON: begin
          nxtLed = 1'b1;
          if (timerFf == 32'h0) begin
            nxtLed   = 1'b0;
            nxtState = MAD_OFF;
            nxtCount = countFf - 4'h1;
            // Long gap after the last blink marks the burst boundary
            nxtTimer = (countFf == 4'h1) ? 32'(GAP_CYC - 1) : 32'(OFF_CYC - 1);
          end else begin
            nxtTimer = timerFf - 32'h1;
          end
        end
        MAD_OFF: begin
          if (timerFf == 32'h0) begin
            nxtState = MAD_ON;
            nxtLed   = 1'b1;
            nxtTimer = 32'(ON_CYC - 1);
            if (countFf == 4'h0) begin
              nxtCount = blinks;
            end
          end else begin
            nxtTimer = timerFf - 32'h1;
          end
        end
        default: nxtState = MAD_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stateFf <= MAD_IDLE;
      timerFf <= 32'h0;
      countFf <= 4'h0;
      ledFf   <= 1'b0;
    end else begin
      stateFf <= nxtState;
      timerFf <= nxtTimer;
      countFf <= nxtCount;
      ledFf   <= nxtLed;
    end
  end

  assign ledOn = ledFf;

endmodule

// ---- design/mad_alarm_detector.sv ----
// Alarm detector for one axis: codes 35h to 51h, LED blinks, clear policy
//
// Function
// [RL1] Other-axis alarm with enable set raises 35h, two blinks, any reset clears.
// [RL2] Controller nonvolatile data corrupt raises 41h, nine blinks, power cycle only.
// [RL3] Position sensor fault at power-up raises 42h, eight blinks, power cycle only.
// [RL4] Shaft rotating at power-up raises 43h, eight blinks, power cycle only.
// [RL5] Sensor nonvolatile data corrupt raises 44h, eight blinks, power cycle only.
// [RL6] Unsupported motor type raises 45h, eight blinks, power cycle only.
// [RL7] Absolute move before coordinate set raises 4Ah, seven blinks, unless permitted.
// [RL8] Regen resistor overheat or absent with enable raises 51h, two blinks.
// [RL9] Host resets each affected axis separately after an other-axis alarm.
// [RL10] Host presets Z-phase or clears trip meter, then cycles power.
// [RL11] Latch latest code in eight bits; repeat blinks until cleared. Here a latched power-cycle alarm keeps later soft codes out.
`timescale 1ns/1ns
module mad_alarm_detector #(
  parameter int ON_CYC  = mad_pkg::BLINK_ON_CYC,
  parameter int OFF_CYC = mad_pkg::BLINK_OFF_CYC,
  parameter int GAP_CYC = mad_pkg::BLINK_GAP_CYC
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire mad_pkg::mad_fault_t  faultIn,
  input  wire mad_pkg::mad_cfg_t    cfgIn,
  input  wire logic                 coordEstablished,
  input  wire logic                 alarmResetReq,
  output mad_pkg::mad_status_t      status,
  output logic                      ledOn
);

  mad_pkg::mad_fault_t sync1Ff, sync2Ff, sync3Ff;
  mad_pkg::mad_fault_t stableFf, nxtStable;
  logic                coordS1Ff, coordS2Ff, coordS3Ff, coordStableFf, nxtCoordStable;
  mad_pkg::mad_fault_t prevFf;
  mad_pkg::mad_status_t statusFf, nxtStatus;
  logic                rstS1Ff, rstS2Ff, rstS3Ff, rstStableFf, nxtRstStable, rstPrevFf;
  logic                rstPulse;
  mad_pkg::mad_fault_t rise;

  // Three-stage synchronisers; a change counts once stages two and three agree
  always_comb begin
    nxtStable      = stableFf;
    nxtCoordStable = coordStableFf;
    nxtRstStable   = rstStableFf;
    for (int i = 0; i < $bits(mad_pkg::mad_fault_t); i++) begin
      if (sync2Ff[i] == sync3Ff[i]) begin
        nxtStable[i] = sync3Ff[i];
      end
    end
    if (coordS2Ff == coordS3Ff) begin
      nxtCoordStable = coordS3Ff;
    end
    if (rstS2Ff == rstS3Ff) begin
      nxtRstStable = rstS3Ff;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1Ff       <= '0;
      sync2Ff       <= '0;
      sync3Ff       <= '0;
      stableFf      <= '0;
      prevFf        <= '0;
      coordS1Ff     <= 1'b0;
      coordS2Ff     <= 1'b0;
      coordS3Ff     <= 1'b0;
      coordStableFf <= 1'b0;
      rstS1Ff       <= 1'b0;
      rstS2Ff       <= 1'b0;
      rstS3Ff       <= 1'b0;
      rstStableFf   <= 1'b0;
      rstPrevFf     <= 1'b0;
    end else begin
      sync1Ff       <= faultIn;
      sync2Ff       <= sync1Ff;
      sync3Ff       <= sync2Ff;
      stableFf      <= nxtStable;
      prevFf        <= stableFf;
      coordS1Ff     <= coordEstablished;
      coordS2Ff     <= coordS1Ff;
      coordS3Ff     <= coordS2Ff;
      coordStableFf <= nxtCoordStable;
      rstS1Ff       <= alarmResetReq;
      rstS2Ff       <= rstS1Ff;
      rstS3Ff       <= rstS2Ff;
      rstStableFf   <= nxtRstStable;
      rstPrevFf     <= rstStableFf;
    end
  end

  // Rising edges only, so a held fault raises once and a reset can clear it
  assign rise     = stableFf & ~prevFf;
  assign rstPulse = rstStableFf & ~rstPrevFf;

  function automatic mad_pkg::mad_status_t mk(input logic [7:0] code,
                                               input logic [3:0] blinks,
                                               input logic       pwrOnly);
    mad_pkg::mad_status_t s;
    s.active         = 1'b1;
    s.powerCycleOnly = pwrOnly;
    s.code           = code;
    s.blinks         = blinks;
    return s;
  endfunction

  // Lowest-priority first, so later assignments win; power-cycle alarms rank highest
  always_comb begin
    nxtStatus = statusFf;
    // A reset clears only soft alarms; a new event in the same cycle still wins
    if (rstPulse && statusFf.active && !statusFf.powerCycleOnly) begin
      nxtStatus = '0;                                                          // [RL1] [RL7] [RL8]
    end
    if (!statusFf.powerCycleOnly) begin
      if (rise.otherAxisAlarm && cfgIn.otherAxisAlarmEnable) begin
        nxtStatus = mk(mad_pkg::CODE_OTHER_AXIS, mad_pkg::BLINK_OTHER_AXIS, 1'b0); // [RL1]
      end
      if (rise.absMoveStart && !coordStableFf && !cfgIn.absMoveWithoutCoordPermit) begin
        nxtStatus = mk(mad_pkg::CODE_NOT_HOMED, mad_pkg::BLINK_NOT_HOMED, 1'b0);   // [RL7]
      end
      if (rise.regenThermalBad && cfgIn.regen_overheat_alarm_enable) begin
        nxtStatus = mk(mad_pkg::CODE_REGEN_HOT, mad_pkg::BLINK_REGEN_HOT, 1'b0);   // [RL8]
      end
    end
    if (rise.motorUnsupported) begin
      nxtStatus = mk(mad_pkg::CODE_MOTOR_TYPE, mad_pkg::BLINK_SENSOR, 1'b1);       // [RL6]
    end
    if (rise.nvmSensCorrupt) begin
      nxtStatus = mk(mad_pkg::CODE_NVM_SENS, mad_pkg::BLINK_SENSOR, 1'b1);         // [RL5]
    end
    if (rise.rotatingPwrup) begin
      nxtStatus = mk(mad_pkg::CODE_ROT_PWRUP, mad_pkg::BLINK_SENSOR, 1'b1);        // [RL4]
    end
    if (rise.sensorFaultPwrup) begin
      nxtStatus = mk(mad_pkg::CODE_SENS_PWRUP, mad_pkg::BLINK_SENSOR, 1'b1);       // [RL3]
    end
    if (rise.nvmCtrlCorrupt) begin
      nxtStatus = mk(mad_pkg::CODE_NVM_CTRL, mad_pkg::BLINK_NVM_CTRL, 1'b1);       // [RL2]
    end
  end

  // Only the power-on reset clears a hard alarm
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      statusFf <= '0;
    end else begin
      statusFf <= nxtStatus;                                                   // [RL11]
    end
  end

  assign status = statusFf;

  mad_led_blinker #(
    .ON_CYC  (ON_CYC),
    .OFF_CYC (OFF_CYC),
    .GAP_CYC (GAP_CYC)
  ) uBlink (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .enable (statusFf.active),
    .blinks (statusFf.blinks),
    .ledOn  (ledOn)                                                            // [RL11]
  );

endmodule

// ---- bench/mad_far_side.sv ----
// Far-side model: position sensor, regen resistor and host driving faults and resets
`timescale 1ns/1ns
module mad_far_side (
  input  wire logic          mclk,
  input  wire logic [7:0]    faultReq,
  input  wire logic          zPresetCmd,
  input  wire logic          resetCmd,
  output mad_pkg::mad_fault_t faultIn,
  output logic               alarmResetReq
);
  always_ff @(posedge mclk) begin
    faultIn <= faultReq;
    // Preset wipes the corrupt sensor memory; only a power cycle then clears the alarm
    if (zPresetCmd)
      faultIn.nvmSensCorrupt <= 1'b0;
    // One reset request per axis, this axis only
    alarmResetReq <= resetCmd;
  end
endmodule

// ---- bench/mad_alarm_detector_asserts.sv ----
// Checker for the alarm detector: code table, clear policy, LED idle
`timescale 1ns/1ns
module mad_alarm_detector_asserts #(
  parameter int ON_CYC  = 3,
  parameter int OFF_CYC = 3,
  parameter int GAP_CYC = 10
) (
  input wire logic                 mclk,
  input wire logic                 rst_n,
  input wire mad_pkg::mad_fault_t  faultIn,
  input wire mad_pkg::mad_cfg_t    cfgIn,
  input wire logic                 coordEstablished,
  input wire logic                 alarmResetReq,
  input wire mad_pkg::mad_status_t status,
  input wire logic                 ledOn
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  function automatic logic ok(mad_pkg::mad_status_t s, logic [7:0] c, logic [3:0] n, logic p);
    return !(s.active && s.code == c) || (s.blinks == n && s.powerCycleOnly == p);
  endfunction
  sequence s_hard;
    status.active && status.powerCycleOnly;
  endsequence
  sequence s_regen;
    $rose(faultIn.regenThermalBad) && cfgIn.regen_overheat_alarm_enable && !status.powerCycleOnly;
  endsequence
  a_other_axis_map: assert property (ok(status, 8'h35, 4'h2, 1'b0)) else $error("35h map");
  a_nvm_ctrl_map: assert property (ok(status, 8'h41, 4'h9, 1'b1)) else $error("41h map");
  a_sensor_map: assert property (ok(status, 8'h42, 4'h8, 1'b1)) else $error("42h map");
  a_rotation_map: assert property (ok(status, 8'h43, 4'h8, 1'b1)) else $error("43h map");
  a_sens_nvm_map: assert property (ok(status, 8'h44, 4'h8, 1'b1)) else $error("44h map");
  a_motor_map: assert property (ok(status, 8'h45, 4'h8, 1'b1)) else $error("45h map");
  a_not_homed_map: assert property (ok(status, 8'h4A, 4'h7, 1'b0)) else $error("4Ah map");
  a_regen_map: assert property (ok(status, 8'h51, 4'h2, 1'b0)) else $error("51h map");
  // Sync stages plus edge detect put the answer five edges out
  a_regen_raise: assert property (s_regen |-> ##[3:7] status.code == 8'h51)
    else $error("51h not raised");
  a_hard_sticky: assert property (s_hard |=> s_hard) else $error("hard alarm dropped");
  a_led_dark: assert property (!status.active [*2] |-> !ledOn) else $error("LED lit idle");
endmodule
bind mad_alarm_detector mad_alarm_detector_asserts #(.ON_CYC(ON_CYC), .OFF_CYC(OFF_CYC),
  .GAP_CYC(GAP_CYC)) u_chk (.mclk(mclk), .rst_n(rst_n), .faultIn(faultIn), .cfgIn(cfgIn),
  .coordEstablished(coordEstablished), .alarmResetReq(alarmResetReq), .status(status),
  .ledOn(ledOn));

// ---- bench/tb.sv ----
// Testbench for the alarm detector: each alarm, its gates, its clearing, LED bursts
`timescale 1ns/1ns
module tb;
  localparam int GAP = 10;
  logic                 mclk;
  logic                 rst_n;
  logic [7:0]           faultReq;
  logic                 zPresetCmd;
  logic                 resetCmd;
  logic                 coordEstablished;
  logic                 alarmResetReq;
  logic                 ledOn;
  mad_pkg::mad_cfg_t    cfgIn;
  mad_pkg::mad_fault_t  faultIn;
  mad_pkg::mad_status_t status;
  int                   n_errors;
  int                   n_checks;
  int                   cycles;
  mad_far_side FAR (.mclk(mclk), .faultReq(faultReq), .zPresetCmd(zPresetCmd),
    .resetCmd(resetCmd), .faultIn(faultIn), .alarmResetReq(alarmResetReq));
  mad_alarm_detector #(.ON_CYC(3), .OFF_CYC(3), .GAP_CYC(GAP)) DUT (.mclk(mclk), .rst_n(rst_n),
    .faultIn(faultIn), .cfgIn(cfgIn), .coordEstablished(coordEstablished),
    .alarmResetReq(alarmResetReq), .status(status), .ledOn(ledOn));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic power_cycle();
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  task automatic raise(input int b);
    faultReq[b] <= 1'b1;
    repeat (8) @(posedge mclk);
    faultReq[b] <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic soft_reset();
    resetCmd <= 1'b1;
    repeat (8) @(posedge mclk);
    resetCmd <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // Finds a gap, then counts rises up to the next gap; off time is shorter than GAP - 2
  task automatic chk_burst(input logic [3:0] n);
    int low;
    int rises;
    logic prev;
    low = 0;
    rises = 0;
    prev = 1'b0;
    while (low < GAP - 2) begin
      @(negedge mclk);
      low = (ledOn === 1'b0) ? low + 1 : 0;
    end
    low = 0;
    while (low < GAP - 2) begin
      @(negedge mclk);
      if (ledOn === 1'b1 && !prev)
        rises++;
      prev = ledOn;
      low = (ledOn === 1'b0) ? low + 1 : 0;
    end
    chk("blink count", {4'h0, n}, 8'(rises));
    @(posedge mclk);
  endtask
  task automatic expect_al(input logic [7:0] code, input logic [3:0] n, input logic pco);
    chk("active", 8'h01, {7'h00, status.active});
    chk("code", code, status.code);
    chk("blinks", {4'h0, n}, {4'h0, status.blinks});
    chk("power cycle only", {7'h00, pco}, {7'h00, status.powerCycleOnly});
    chk_burst(n);
  endtask
  task automatic s_hard(input int b, input logic [7:0] code, input logic [3:0] n);
    power_cycle();
    raise(b);
    expect_al(code, n, 1'b1);
    soft_reset();
    raise(0);
    chk("hard code kept", code, status.code);
    zPresetCmd <= 1'b1;
    @(posedge mclk);
    zPresetCmd <= 1'b0;
    power_cycle();
    chk("cleared by power", 8'h00, {7'h00, status.active});
  endtask
  task automatic s_soft(input int b, input mad_pkg::mad_cfg_t off, input logic [7:0] code,
      input logic [3:0] n);
    power_cycle();
    cfgIn <= off;
    raise(b);
    chk("gated alarm", 8'h00, {7'h00, status.active});
    cfgIn <= 3'b110;
    raise(b);
    expect_al(code, n, 1'b0);
    soft_reset();
    chk("soft cleared", 8'h00, {7'h00, status.active});
  endtask
  task automatic s_latest();
    power_cycle();
    coordEstablished <= 1'b1;
    raise(7);
    raise(1);
    chk("coord set refuses", 8'h35, status.code);
    coordEstablished <= 1'b0;
    raise(0);
    chk("latest code", 8'h51, status.code);
  endtask
  initial begin
    rst_n = 1'b0;
    faultReq = 8'h00;
    zPresetCmd = 1'b0;
    resetCmd = 1'b0;
    cfgIn = 3'b110;
    coordEstablished = 1'b0;
    n_errors = 0;
    n_checks = 0;
    s_hard(6, 8'h41, 4'h9);
    s_hard(5, 8'h42, 4'h8);
    s_hard(4, 8'h43, 4'h8);
    s_hard(3, 8'h44, 4'h8);
    s_hard(2, 8'h45, 4'h8);
    s_soft(7, 3'b000, 8'h35, 4'h2);
    s_soft(1, 3'b111, 8'h4A, 4'h7);
    s_soft(0, 3'b000, 8'h51, 4'h2);
    s_latest();
    conclude();
  end
endmodule
